/* design/adc_sequencer_control.sv */
`timescale 1ns/1ns
// Notes on behaviour
// - clock select codes give 2..64 periods, x11 RC
// - manual acquisition delays start one instruction cycle
// - calibration dummy conversion stores offset, subtracted later
// - selected pin converted regardless of direction
// - analog pins read zero on port read
// - strap picks port reset PCFG 0 or 1; both leave all 13 pins analog
// - acquisition code 010 samples four bit periods
// - abort keeps result registers unchanged
// - two bit periods wait, then sampling resumes
// - compare trigger in mode 1011 sets go
// - converter off ignores trigger, timer still reset
// - completion loads result (offset on calibration run), clears go, flags done
// - acquisition field gives 2..20 periods, 000 manual
// - conversion takes eleven bit periods
module adc_sequencer_control (
    input  wire logic                          i_clock,
    input  wire logic                          i_resetn,
    input  wire logic [adc_seq_pkg::ADDR_W-1:0] i_addr,
    input  wire logic [7:0]                    i_wdata,
    input  wire logic                          i_write,
    input  wire logic                          i_read,
    output logic      [7:0]                    o_rdata,
    input  wire logic                          i_portb_analog_reset_cfg,
    input  wire logic [3:0]                    i_compare2_mode,
    input  wire logic                          i_special_event,
    output logic                               o_timer_reset,
    input  wire logic                          i_rc_clock,
    input  wire logic                          i_comp_high,
    input  wire logic [adc_seq_pkg::CHANNELS-1:0] i_pin_levels,
    output logic      [adc_seq_pkg::CHANNELS-1:0] o_port_read,
    output logic      [3:0]                    o_channel_select,
    output logic      [1:0]                    o_ref_select,
    output logic                               o_sample,
    output logic                               o_cal_mode,
    output logic      [adc_seq_pkg::RESULT_W-1:0] o_dac_code,
    output logic                               o_conv_done_set
);
    import adc_seq_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    state_t                state_q, state_d;
    logic                  on_q, on_d, go_q, go_d, cal_q, cal_d;
    logic [3:0]            chan_q, chan_d, pcfg_q, pcfg_d;
    logic [1:0]            ref_q, ref_d;
    logic                  fmt_q, fmt_d;
    logic [2:0]            acq_q, acq_d, clk_q, clk_d, dly_q, dly_d;
    logic [4:0]            cnt_q, cnt_d;
    logic [7:0]            res_hi_q, res_hi_d, res_lo_q, res_lo_d, rdata_q, rdata_d;
    logic [RESULT_W-1:0]   offset_q, offset_d, corr;
    logic                  cal_run_q, cal_run_d, done_q, done_d, trst_q, trst_d;
    logic [CHANNELS-1:0]   s1_q, s2_q, s3_q, lvl_q, lvl_d, prd_q, prd_d, amask;
    logic                  wr0, sw_go_set, sw_go_clr, trig_hit, hw_go, start_req;
    logic                  busy_st, abort_req, sar_start, sar_abort;
    logic                  tad_tick, sar_busy, sar_done;
    logic [RESULT_W-1:0]   sar_code, sar_result;

    tad_tick_gen u_tick (
        .i_clock        (i_clock),
        .i_resetn       (i_resetn),
        .i_clock_select (clk_q),
        .i_rc_clock     (i_rc_clock),
        .i_run          (state_q != ST_OFF),
        .o_tick         (tad_tick)
    );

    sar_engine #(.WIDTH(RESULT_W)) u_sar (
        .i_clock     (i_clock),
        .i_resetn    (i_resetn),
        .i_tick      (tad_tick),
        .i_start     (sar_start),
        .i_abort     (sar_abort),
        .i_comp_high (i_comp_high),
        .o_busy      (sar_busy),
        .o_done      (sar_done),
        .o_code      (sar_code),
        .o_result    (sar_result)
    );

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        wr0       = i_write && (i_addr == OFS_CTL0);
        // Go only honoured once the converter is already on
        sw_go_set = wr0 && i_wdata[CTL0_GO_BIT] && i_wdata[CTL0_ON_BIT] && on_q;
        sw_go_clr = wr0 && !i_wdata[CTL0_GO_BIT];
        trig_hit  = i_special_event && (i_compare2_mode == CMP2_TRIGGER_MODE);
        hw_go     = trig_hit && on_q;
        start_req = (sw_go_set || hw_go) && (state_q == ST_SAMPLE);
        busy_st   = (state_q == ST_DELAY) || (state_q == ST_ACQ) || (state_q == ST_CONV);
        abort_req = sw_go_clr && !hw_go && busy_st;
        corr      = (sar_result > offset_q) ? RESULT_W'(sar_result - offset_q) : '0;
        for (int i = 0; i < CHANNELS; i++) begin
            amask[i] = (i + int'(pcfg_q)) < 15;
        end
        state_d   = state_q;
        on_d      = on_q;
        go_d      = go_q;
        cal_d     = cal_q;
        chan_d    = chan_q;
        pcfg_d    = pcfg_q;
        ref_d     = ref_q;
        fmt_d     = fmt_q;
        acq_d     = acq_q;
        clk_d     = clk_q;
        dly_d     = dly_q;
        cnt_d     = cnt_q;
        res_hi_d  = res_hi_q;
        res_lo_d  = res_lo_q;
        offset_d  = offset_q;
        cal_run_d = cal_run_q;
        done_d    = 1'b0;
        trst_d    = trig_hit;
        sar_start = 1'b0;
        sar_abort = 1'b0;
        // Plain register writes
        if (i_write) begin
            unique case (i_addr)
                OFS_RESULT_HI: res_hi_d = i_wdata;
                OFS_RESULT_LO: res_lo_d = i_wdata;
                OFS_CTL0: begin
                    on_d   = i_wdata[CTL0_ON_BIT];
                    cal_d  = i_wdata[CTL0_CAL_BIT];
                    chan_d = i_wdata[CTL0_CHAN_LSB +: 4];
                end
                OFS_CTL1: begin
                    ref_d  = i_wdata[CTL1_REF_LSB +: 2];
                    pcfg_d = i_wdata[CTL1_PCFG_LSB +: 4];
                end
                OFS_CTL2: begin
                    fmt_d = i_wdata[CTL2_FMT_BIT];
                    acq_d = i_wdata[CTL2_ACQ_LSB +: 3];
                    clk_d = i_wdata[CTL2_CLK_LSB +: 3];
                end
                default: ;
            endcase
        end
        unique case (state_q)
            ST_OFF: if (on_d) state_d = ST_SAMPLE;
            ST_SAMPLE: if (start_req) begin
                go_d      = 1'b1;
                cal_run_d = cal_q;
                if (acq_q == 3'h0) begin
                    state_d = ST_DELAY;
                    dly_d   = 3'(INSTR_CYCLE_CLKS);
                end else begin
                    state_d = ST_ACQ;
                    cnt_d   = acq_tads(acq_q);
                end
            end
            ST_DELAY: if (dly_q == 3'h1) begin
                state_d   = ST_CONV;
                sar_start = 1'b1;
            end else begin
                dly_d = 3'(dly_q - 3'h1);
            end
            ST_ACQ: if (tad_tick) begin
                if (cnt_q == 5'h01) begin
                    state_d   = ST_CONV;
                    sar_start = 1'b1;
                end else begin
                    cnt_d = 5'(cnt_q - 5'h01);
                end
            end
            ST_CONV: if (sar_done) begin
                state_d = ST_WAIT;
                cnt_d   = WAIT_TADS;
                go_d    = 1'b0;
                done_d  = 1'b1;
                if (cal_run_q) begin
                    offset_d = sar_result;
                    cal_d    = 1'b0;
                end else if (fmt_q) begin
                    res_hi_d = {6'h00, corr[9:8]};
                    res_lo_d = corr[7:0];
                end else begin
                    res_hi_d = corr[9:2];
                    res_lo_d = {corr[1:0], 6'h00};
                end
                cal_run_d = 1'b0;
            end
            ST_WAIT: if (tad_tick) begin
                if (cnt_q == 5'h01) state_d = ST_SAMPLE;
                else cnt_d = 5'(cnt_q - 5'h01);
            end
            default: state_d = ST_OFF;
        endcase
        // Abort from any busy state; result registers left alone
        if (abort_req) begin
            state_d   = ST_WAIT;
            cnt_d     = WAIT_TADS;
            go_d      = 1'b0;
            sar_abort = 1'b1;
            cal_run_d = 1'b0;
            res_hi_d  = res_hi_q;
            res_lo_d  = res_lo_q;
        end
        if (!on_d) begin
            state_d   = ST_OFF;
            go_d      = 1'b0;
            sar_abort = 1'b1;
            cal_run_d = 1'b0;
        end
        // Port pins: analog-configured pins read as zero
        for (int i = 0; i < CHANNELS; i++) begin
            lvl_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : lvl_q[i];
        end
        prd_d   = lvl_d & ~amask;
        rdata_d = 8'h00;
        if (i_read) begin
            unique case (i_addr)
                OFS_RESULT_HI: rdata_d = res_hi_q;
                OFS_RESULT_LO: rdata_d = res_lo_q;
                OFS_CTL0: rdata_d = {cal_q, 1'b0, chan_q, go_q, on_q};
                OFS_CTL1: rdata_d = {2'h0, ref_q, pcfg_q};
                OFS_CTL2: rdata_d = {fmt_q, 1'b0, acq_q, clk_q};
                default:  rdata_d = 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            state_q <= ST_OFF;
            {on_q, go_q, cal_q, fmt_q, cal_run_q, done_q, trst_q} <= 7'h00;
            {chan_q, ref_q, acq_q, clk_q, dly_q, cnt_q} <= 20'h00000;
            // Strap sampled while reset is held
            pcfg_q <= i_portb_analog_reset_cfg ? PCFG_RESET_ANALOG : PCFG_RESET_DIGITAL;
            {res_hi_q, res_lo_q, rdata_q} <= 24'h000000;
            offset_q <= '0;
            {s1_q, s2_q, s3_q, lvl_q, prd_q} <= '0;
        end else begin
            state_q <= state_d;
            {on_q, go_q, cal_q, fmt_q} <= {on_d, go_d, cal_d, fmt_d};
            {cal_run_q, done_q, trst_q} <= {cal_run_d, done_d, trst_d};
            {chan_q, pcfg_q, ref_q} <= {chan_d, pcfg_d, ref_d};
            {acq_q, clk_q, dly_q, cnt_q} <= {acq_d, clk_d, dly_d, cnt_d};
            {res_hi_q, res_lo_q, rdata_q} <= {res_hi_d, res_lo_d, rdata_d};
            offset_q <= offset_d;
            {s3_q, s2_q, s1_q} <= {s2_q, s1_q, i_pin_levels};
            {lvl_q, prd_q} <= {lvl_d, prd_d};
        end
    end

    // Channel goes to the mux unqualified by pin direction
    assign o_channel_select = chan_q;
    assign o_ref_select     = ref_q;
    assign o_sample         = (state_q == ST_SAMPLE) || (state_q == ST_DELAY) ||
                              (state_q == ST_ACQ);
    assign o_cal_mode       = cal_run_q;
    assign o_dac_code       = sar_code;
    assign o_conv_done_set  = done_q;
    assign o_timer_reset    = trst_q;
    assign o_rdata          = rdata_q;
    assign o_port_read      = prd_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    logic [3:0] conv_ticks_q;
    logic [4:0] acq_ticks_q;
    always_ff @(posedge i_clock) begin
        if (!i_resetn || state_q != ST_CONV) conv_ticks_q <= 4'h0;
        else if (tad_tick) conv_ticks_q <= 4'(conv_ticks_q + 4'h1);
        if (!i_resetn || state_q != ST_ACQ) acq_ticks_q <= 5'h00;
        else if (tad_tick) acq_ticks_q <= 5'(acq_ticks_q + 5'h01);
    end

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_resetn);

    property p_tick_div2;
        (tad_tick && clk_q == 3'h0 && on_q && !i_write) |=> !tad_tick;
    endproperty
    a_tick_div2: assert property (p_tick_div2) else $error("bit period too short");
    property p_manual_delay;
        (start_req && acq_q == 3'h0 && on_d && !abort_req) |=>
            (state_q != ST_CONV)[*4] ##1 (state_q != ST_DELAY);
    endproperty
    a_manual_delay: assert property (p_manual_delay) else $error("manual start delay wrong");
    property p_cal_offset;
        (state_q == ST_CONV && sar_done && cal_run_q && on_d && !abort_req) |=>
            offset_q == $past(sar_result) && $stable(res_hi_q) && !o_cal_mode;
    endproperty
    a_cal_offset: assert property (p_cal_offset) else $error("offset not stored");
    property p_acq4;
        (state_q == ST_ACQ && state_d == ST_CONV && acq_q == 3'h2) |-> acq_ticks_q == 5'h03;
    endproperty
    a_acq4: assert property (p_acq4) else $error("acquisition length wrong");
    property p_abort;
        (abort_req && on_d) |=> state_q == ST_WAIT && $stable(res_hi_q) &&
            $stable(res_lo_q) && !go_q;
    endproperty
    a_abort: assert property (p_abort) else $error("abort misbehaved");
    property p_wait2;
        (state_d == ST_WAIT && state_q != ST_WAIT) |=> cnt_q == WAIT_TADS;
    endproperty
    a_wait2: assert property (p_wait2) else $error("post wait not two periods");
    property p_trig_on;
        (hw_go && state_q == ST_SAMPLE && on_d && !abort_req) |=> go_q && o_timer_reset;
    endproperty
    a_trig_on: assert property (p_trig_on) else $error("trigger did not start");
    property p_trig_off;
        (trig_hit && !on_q && !on_d) |=> o_timer_reset && !go_q && state_q == ST_OFF;
    endproperty
    a_trig_off: assert property (p_trig_off) else $error("trigger not ignored");
    property p_done;
        (state_q == ST_CONV && sar_done && on_d && !abort_req) |=>
            !go_q && o_conv_done_set ##1 !o_conv_done_set;
    endproperty
    a_done: assert property (p_done) else $error("completion handling wrong");
    property p_eleven;
        (sar_done && state_q == ST_CONV) |-> conv_ticks_q == 4'(CONV_TADS);
    endproperty
    a_eleven: assert property (p_eleven) else $error("conversion length wrong");
    c_conv_done: cover property (o_conv_done_set && !cal_run_q);
    c_cal_done: cover property (state_q == ST_CONV && sar_done && cal_run_q);
    c_abort: cover property (abort_req && state_q == ST_CONV);
    c_trigger: cover property (hw_go && state_q == ST_SAMPLE);
endmodule : adc_sequencer_control

/* design/adc_seq_pkg.sv */
package adc_seq_pkg;
    // ------------------------------------------------------------
    // Register offsets and fields
    // ------------------------------------------------------------
    localparam int         ADDR_W          = 3;
    localparam logic [2:0] OFS_RESULT_HI   = 3'h0;
    localparam logic [2:0] OFS_RESULT_LO   = 3'h1;
    localparam logic [2:0] OFS_CTL0        = 3'h2;
    localparam logic [2:0] OFS_CTL1        = 3'h3;
    localparam logic [2:0] OFS_CTL2        = 3'h4;
    localparam int         CTL0_CAL_BIT    = 7;
    localparam int         CTL0_CHAN_LSB   = 2;
    localparam int         CTL0_GO_BIT     = 1;
    localparam int         CTL0_ON_BIT     = 0;
    localparam int         CTL1_REF_LSB    = 4;
    localparam int         CTL1_PCFG_LSB   = 0;
    localparam int         CTL2_FMT_BIT    = 7;
    localparam int         CTL2_ACQ_LSB    = 3;
    localparam int         CTL2_CLK_LSB    = 0;
    localparam logic [3:0] PCFG_RESET_ANALOG  = 4'h0;
    localparam logic [3:0] PCFG_RESET_DIGITAL = 4'h1;
    localparam logic [3:0] CMP2_TRIGGER_MODE  = 4'hB;
    localparam int         CHANNELS        = 13;
    localparam int         RESULT_W        = 10;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLOCK_PERIOD_NS  = 20;
    localparam int INSTR_CYCLE_NS   = 80;
    localparam int INSTR_CYCLE_CLKS =
        (INSTR_CYCLE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam logic [4:0] WAIT_TADS = 5'h02;
    localparam int         CONV_TADS = 11;

    typedef enum logic [2:0] {
        ST_OFF    = 3'b000,
        ST_SAMPLE = 3'b001,
        ST_DELAY  = 3'b010,
        ST_ACQ    = 3'b011,
        ST_CONV   = 3'b100,
        ST_WAIT   = 3'b101
    } state_t;

    function automatic logic [4:0] acq_tads(input logic [2:0] code);
        logic [4:0] n;
        n = 5'h00;
        unique case (code)
            3'h0: n = 5'h00;
            3'h1: n = 5'h02;
            3'h2: n = 5'h04;
            3'h3: n = 5'h06;
            3'h4: n = 5'h08;
            3'h5: n = 5'h0C;
            3'h6: n = 5'h10;
            3'h7: n = 5'h14;
        endcase
        return n;
    endfunction : acq_tads
endpackage : adc_seq_pkg

/* design/tad_tick_gen.sv */
`timescale 1ns/1ns
module tad_tick_gen (
    input  wire logic       i_clock,
    input  wire logic       i_resetn,
    input  wire logic [2:0] i_clock_select,
    input  wire logic       i_rc_clock,
    input  wire logic       i_run,
    output logic            o_tick
);
    import adc_seq_pkg::*;

    logic [2:0] rc_sync_q, rc_sync_d;
    logic       rc_level_q, rc_level_d;
    logic [6:0] div_q, div_d;
    logic       tick_q, tick_d;
    logic [6:0] limit;
    logic       use_rc;

    always_comb begin
        use_rc     = (i_clock_select[1:0] == 2'h3);
        limit      = 7'((7'h02 << {i_clock_select[1:0], i_clock_select[2]}) - 7'h01);
        rc_sync_d  = {rc_sync_q[1:0], i_rc_clock};
        // Level changes only once second and third stage agree
        rc_level_d = (rc_sync_q[1] == rc_sync_q[2]) ? rc_sync_q[2] : rc_level_q;
        div_d      = (!i_run || div_q >= limit) ? 7'h00 : 7'(div_q + 7'h01);
        tick_d     = 1'b0;
        if (i_run) begin
            tick_d = use_rc ? (rc_level_d & ~rc_level_q) : (div_q == limit);
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            rc_sync_q  <= 3'h0;
            rc_level_q <= 1'b0;
            div_q      <= 7'h00;
            tick_q     <= 1'b0;
        end else begin
            rc_sync_q  <= rc_sync_d;
            rc_level_q <= rc_level_d;
            div_q      <= div_d;
            tick_q     <= tick_d;
        end
    end

    assign o_tick = tick_q;
endmodule : tad_tick_gen

/* design/sar_engine.sv */
`timescale 1ns/1ns
module sar_engine #(
    parameter int WIDTH = 10
) (
    input  wire logic             i_clock,
    input  wire logic             i_resetn,
    input  wire logic             i_tick,
    input  wire logic             i_start,
    input  wire logic             i_abort,
    input  wire logic             i_comp_high,
    output logic                  o_busy,
    output logic                  o_done,
    output logic [WIDTH-1:0]      o_code,
    output logic [WIDTH-1:0]      o_result
);
    import adc_seq_pkg::*;

    // Step counter is four bits wide
    if (WIDTH < 2 || WIDTH > 14) begin : g_width_check
        $error("sar_engine: WIDTH out of range");
    end

    logic             busy_q, busy_d;
    logic             done_q, done_d;
    logic [3:0]       step_q, step_d;
    logic [WIDTH-1:0] code_q, code_d;
    logic [WIDTH-1:0] result_q, result_d;
    int               idx;

    // One setup period, then one decision per bit period
    always_comb begin
        idx      = 0;
        busy_d   = busy_q;
        done_d   = 1'b0;
        step_d   = step_q;
        code_d   = code_q;
        result_d = result_q;
        if (i_start) begin
            busy_d = 1'b1;
            step_d = 4'h0;
            code_d = '0;
        end else if (i_abort) begin
            busy_d = 1'b0;
        end else if (busy_q && i_tick) begin
            step_d = 4'(step_q + 4'h1);
            if (step_q == 4'h0) begin
                code_d[WIDTH-1] = 1'b1;
            end else begin
                idx = WIDTH - int'(step_q);
                for (int i = 0; i < WIDTH; i++) begin
                    if (i == idx) code_d[i] = i_comp_high;
                    else if (i == idx - 1) code_d[i] = 1'b1;
                end
                if (int'(step_q) == WIDTH) begin
                    busy_d   = 1'b0;
                    done_d   = 1'b1;
                    result_d = code_d;
                end
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            busy_q   <= 1'b0;
            done_q   <= 1'b0;
            step_q   <= 4'h0;
            code_q   <= '0;
            result_q <= '0;
        end else begin
            busy_q   <= busy_d;
            done_q   <= done_d;
            step_q   <= step_d;
            code_q   <= code_d;
            result_q <= result_d;
        end
    end

    assign o_busy   = busy_q;
    assign o_done   = done_q;
    assign o_code   = code_q;
    assign o_result = result_q;
endmodule : sar_engine

/* bench/adc_sequencer_control_tb.sv */
`timescale 1ns/1ns
module adc_sequencer_control_tb;
    import adc_seq_pkg::*;
    logic        i_clock, i_resetn, i_write, i_read, i_special_event, i_rc_clock;
    logic [2:0]  i_addr;
    logic [7:0]  i_wdata, o_rdata;
    logic [12:0] o_port_read;
    logic        o_timer_reset, o_sample, o_cal_mode, o_conv_done_set, cal_seen;
    logic        strap;
    logic [3:0]  o_channel_select;
    logic [1:0]  o_ref_select;
    logic [9:0]  o_dac_code;
    int          err_count = 0;
    int          checked = 0;
    int          n;
    logic [2:0]  cs[7] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3};
    int          ps[7] = '{2, 4, 8, 16, 32, 64, 6};

    adc_sequencer_control dut (.i_clock(i_clock), .i_resetn(i_resetn), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_write(i_write), .i_read(i_read), .o_rdata(o_rdata),
        .i_portb_analog_reset_cfg(strap), .i_compare2_mode(4'hB),
        .i_special_event(i_special_event), .o_timer_reset(o_timer_reset),
        .i_rc_clock(i_rc_clock), .i_comp_high(1'b1), .i_pin_levels(13'h1FFF),
        .o_port_read(o_port_read), .o_channel_select(o_channel_select),
        .o_ref_select(o_ref_select), .o_sample(o_sample), .o_cal_mode(o_cal_mode),
        .o_dac_code(o_dac_code), .o_conv_done_set(o_conv_done_set));

    // ------------------------------------------------------------
    // Bus and check tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [12:0] got, input logic [12:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge i_clock);
        i_addr  <= a;
        i_wdata <= d;
        i_write <= 1'b1;
        @(posedge i_clock);
        i_write <= 1'b0;
    endtask : wr

    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        @(posedge i_clock);
        i_addr <= a;
        i_read <= 1'b1;
        @(posedge i_clock);
        i_read <= 1'b0;
        #1 chk(o_rdata, e);
    endtask : rd

    task automatic pulse();
        @(posedge i_clock);
        i_special_event <= 1'b1;
        @(posedge i_clock);
        i_special_event <= 1'b0;
        #1 chk(o_timer_reset, 1'b1);
    endtask : pulse

    // Length window is loose: tick phase at start is unknown
    task automatic run(input bit trig, input logic [7:0] c0, input int lo, input int hi);
        if (trig) pulse();
        else wr(3'h2, c0);
        n = 0;
        cal_seen = 1'b0;
        while (o_conv_done_set !== 1'b1 && n < 3000) begin
            @(posedge i_clock);
            #1 n++;
            cal_seen |= o_cal_mode;
        end
        chk(13'(n >= lo && n <= hi), 13'h1);
        repeat (2 * hi) @(posedge i_clock);
    endtask : run

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : give_verdict

    // ------------------------------------------------------------
    // Clocks, watchdog, tests
    // ------------------------------------------------------------
    initial begin
        i_clock = 1'b0;
        forever #10 i_clock = ~i_clock;
    end
    initial begin
        i_rc_clock = 1'b0;
        forever #60 i_rc_clock = ~i_rc_clock;
    end
    initial begin
        #600000;
        err_count++;
        give_verdict();
    end

    initial begin
        i_resetn = 1'b0;
        i_write = 1'b0;
        i_read = 1'b0;
        i_addr = 3'h0;
        i_wdata = 8'h00;
        i_special_event = 1'b0;
        strap = 1'b1;
        repeat (8) @(posedge i_clock);
        i_resetn <= 1'b1;
        rd(3'h4, 8'h00);
        rd(3'h3, 8'h00);
        chk(o_port_read, 13'h0000);
        wr(3'h3, 8'h3F);
        repeat (6) @(posedge i_clock);
        #1 chk(o_port_read, 13'h1FFF);
        chk(13'(o_ref_select), 13'h0003);
        wr(3'h2, 8'h03);
        rd(3'h2, 8'h01);
        $display("reset and port test done");
        for (int k = 0; k < 7; k++) begin
            wr(3'h4, {5'h00, cs[k]});
            run(1'b0, 8'h03, 10 * ps[k], 13 * ps[k] + 8);
            rd(3'h2, 8'h01);
            rd(3'h0, 8'hFF);
            chk(13'(o_dac_code), 13'h03FF);
            $display("clock select test %0d done", k);
        end
        wr(3'h4, 8'h10);
        run(1'b0, 8'h03, 28, 42);
        wr(3'h0, 8'h5A);
        wr(3'h2, 8'h03);
        repeat (20) @(posedge i_clock);
        wr(3'h2, 8'h01);
        repeat (2) @(posedge i_clock);
        #1 chk(o_sample, 1'b0);
        repeat (8) @(posedge i_clock);
        #1 chk(o_sample, 1'b1);
        rd(3'h0, 8'h5A);
        rd(3'h2, 8'h01);
        $display("abort test done");
        wr(3'h4, 8'h00);
        run(1'b1, 8'h00, 20, 42);
        wr(3'h2, 8'h81);
        run(1'b0, 8'h83, 20, 42);
        chk(cal_seen, 1'b1);
        rd(3'h2, 8'h01);
        run(1'b0, 8'h03, 20, 42);
        rd(3'h0, 8'h00);
        $display("trigger and calibration test done");
        wr(3'h2, 8'h28);
        #1 chk(13'(o_channel_select), 13'h000A);
        pulse();
        rd(3'h2, 8'h28);
        $display("trigger while off test done");
        @(posedge i_clock);
        strap <= 1'b0;
        i_resetn <= 1'b0;
        repeat (3) @(posedge i_clock);
        i_resetn <= 1'b1;
        rd(3'h3, 8'h01);
        $display("second reset test done");
        give_verdict();
    end
endmodule : adc_sequencer_control_tb
